// [core/msc_defines.svh]
// Timing counts and reset values for the module sideband control block
`ifndef MSC_DEFINES_SVH
`define MSC_DEFINES_SVH

// Minimum reset pulse length in ns, and the cycle count rounded up at 25 MHz
`define MSC_CLK_PERIOD_NS      40
`define MSC_RESET_PULSE_NS     2000
`define MSC_RESET_PULSE_CYC    ((`MSC_RESET_PULSE_NS + `MSC_CLK_PERIOD_NS - 1) / `MSC_CLK_PERIOD_NS)
// Initialization time in ns, and the cycle count rounded down at 25 MHz
`define MSC_INIT_TIME_NS       2000000
`define MSC_INIT_TIME_CYC      (`MSC_INIT_TIME_NS / `MSC_CLK_PERIOD_NS)
// Number of breakout ends
`define MSC_NUM_ENDS           4
// Width of the setting word restored on reset
`define MSC_SETTINGS_W         8
`define MSC_SETTINGS_DEFAULT   8'h00

`endif

// [core/msc_pkg.sv]
// Types for the module sideband control block
`default_nettype none
package msc_pkg;
    typedef enum logic [1:0] {
        MSC_ST_IDLE    = 2'b00,
        MSC_ST_HELD    = 2'b01,
        MSC_ST_INIT    = 2'b10,
        MSC_ST_READY   = 2'b11
    } msc_state_t;
endpackage
`default_nettype wire

// [core/msc_pulse_filter.sv]
// Counts how long the reset input stays low and flags a qualified pulse
`default_nettype none
module msc_pulse_filter #(
    parameter int CNT_W   = 8,
    parameter int MIN_CYC = 50
) (
    // Clock and reset
    input  wire logic ref_clk,
    input  wire logic rst_n,
    // Reset input as seen after the internal pull-up
    input  wire logic level_n,
    // Qualified low pulse seen, held until the input goes high
    output logic      long_low
);
    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic             long_low;
    } msc_pf_st_t;

    msc_pf_st_t st_r;
    msc_pf_st_t st_nxt;

    always_comb begin
        st_nxt = st_r;
        if (level_n) begin
            st_nxt.cnt      = '0;
            st_nxt.long_low = 1'b0;
        end else if (st_r.cnt >= CNT_W'(MIN_CYC - 1)) begin
            st_nxt.long_low = 1'b1;
        end else begin
            st_nxt.cnt = st_r.cnt + CNT_W'(1);
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign long_low = st_r.long_low;
endmodule // msc_pulse_filter
`default_nettype wire

// [core/msc_init_timer.sv]
// Counts the initialization interval once started and flags its end
`default_nettype none
module msc_init_timer #(
    parameter int CNT_W    = 17,
    parameter int INIT_CYC = 50000
) (
    // Clock and reset
    input  wire logic ref_clk,
    input  wire logic rst_n,
    // Start pulse and abort level
    input  wire logic start,
    input  wire logic abort,
    // One-cycle pulse when the interval ends
    output logic      done
);
    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic             run;
        logic             done;
    } msc_it_st_t;

    msc_it_st_t st_r;
    msc_it_st_t st_nxt;

    always_comb begin
        st_nxt      = st_r;
        st_nxt.done = 1'b0;
        if (abort) begin
            st_nxt.run = 1'b0;
            st_nxt.cnt = '0;
        end else if (start) begin
            st_nxt.run = 1'b1;
            st_nxt.cnt = '0;
        end else if (st_r.run) begin
            if (st_r.cnt >= CNT_W'(INIT_CYC - 1)) begin
                st_nxt.run  = 1'b0;
                st_nxt.done = 1'b1;
            end else begin
                st_nxt.cnt = st_r.cnt + CNT_W'(1);
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign done = st_r.done;
endmodule // msc_init_timer
`default_nettype wire

// [core/msc_sideband.sv]
// Sideband control and status logic of a pluggable cable end
// What this block does
// - Reset input held low past minimum pulse fully resets, restoring default settings.
// - Initialization interval starts at the rising edge releasing the reset input.
// - Completion is signalled by asserting attention while data-not-ready reads clear.
// - After power-up the completion attention is posted without a reset pulse.
// - Reset input internally pulled high; undriven means not in reset.
// - Power-save input high puts the device in reduced power below one watt.
// - Presence output is low while inserted; host sees high when absent.
// - Attention output driven low to report fault or critical status.
// - Attention output only pulls low, otherwise released for host pull-up.
// - Each end's transmitter off when disable input high or open.
// - Each end's transmitter-fault output held permanently low.
// - Each end ignores both rate-select inputs entirely.
// - Each end's absent indication tied low inside the device.
// - Serial commands answered only while the select input is low.
`include "msc_defines.svh"
`default_nettype none
module msc_sideband #(
    parameter int NUM_ENDS  = `MSC_NUM_ENDS,
    parameter int PULSE_CYC = `MSC_RESET_PULSE_CYC,
    parameter int INIT_CYC  = `MSC_INIT_TIME_CYC
) (
    // Clock and reset
    input  wire logic                       ref_clk,
    input  wire logic                       rst_n,
    // Host reset input: value and whether the host drives it
    input  wire logic                       reset_n_input,
    input  wire logic                       reset_n_driven,
    // Host controls
    input  wire logic                       power_save_input,
    input  wire logic                       select_n_input,
    // Serial bus request and status read
    input  wire logic                       serial_req,
    input  wire logic                       status_read,
    // Fault and critical status sources
    input  wire logic                       fault_event,
    input  wire logic                       critical_event,
    // Per breakout end: transmit disable value and driven flag, rate selects
    input  wire logic [NUM_ENDS-1:0]        tx_disable_in,
    input  wire logic [NUM_ENDS-1:0]        tx_disable_driven,
    input  wire logic [NUM_ENDS-1:0]        rate_select_zero,
    input  wire logic [NUM_ENDS-1:0]        rate_select_one,
    input  wire logic [NUM_ENDS-1:0]        loss_detect,
    // Attention open-drain pin
    output logic                            attention_n_out,
    output logic                            attention_n_oe,
    // Presence and status
    output logic                            present_n_output,
    output logic                            data_not_ready,
    output logic                            low_power_active,
    output logic                            serial_ack,
    output logic [`MSC_SETTINGS_W-1:0]      user_settings,
    // Per breakout end outputs
    output logic [NUM_ENDS-1:0]             tx_enable,
    output logic [NUM_ENDS-1:0]             tx_fault,
    output logic [NUM_ENDS-1:0]             absent_indication,
    output logic [NUM_ENDS-1:0]             receive_signal_lost
);
    // ****************************************************************
    // Pin conditioning
    // ****************************************************************
    logic reset_level_n;
    logic long_low;
    logic init_done;
    logic init_start;
    logic [NUM_ENDS-1:0] tx_dis_eff;

    assign reset_level_n = reset_n_driven ? reset_n_input : 1'b1;

    genvar g;
    generate
        for (g = 0; g < NUM_ENDS; g++) begin : g_end
            assign tx_dis_eff[g] = tx_disable_driven[g] ? tx_disable_in[g] : 1'b1;
        end
    endgenerate

    msc_pulse_filter #(
        .CNT_W   ($clog2(PULSE_CYC + 1)),
        .MIN_CYC (PULSE_CYC)
    ) u_pulse (
        .ref_clk  (ref_clk),
        .rst_n    (rst_n),
        .level_n  (reset_level_n),
        .long_low (long_low)
    );

    msc_init_timer #(
        .CNT_W    ($clog2(INIT_CYC + 1)),
        .INIT_CYC (INIT_CYC)
    ) u_init (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .start   (init_start),
        .abort   (long_low),
        .done    (init_done)
    );

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        msc_pkg::msc_state_t         state;
        logic                        dnr;
        logic                        att;
        logic                        lp;
        logic                        ack;
        logic [`MSC_SETTINGS_W-1:0]  settings;
        logic [NUM_ENDS-1:0]         tx_en;
        logic [NUM_ENDS-1:0]         los;
    } msc_st_t;

    msc_st_t st_r;
    msc_st_t st_nxt;

    assign init_start = (st_r.state == msc_pkg::MSC_ST_IDLE)
                      || (st_r.state == msc_pkg::MSC_ST_HELD && reset_level_n);

    always_comb begin
        st_nxt     = st_r;
        st_nxt.ack = 1'b0;
        case (st_r.state)
            msc_pkg::MSC_ST_IDLE: begin
                st_nxt.state = msc_pkg::MSC_ST_INIT;
                st_nxt.dnr   = 1'b1;
            end
            msc_pkg::MSC_ST_HELD: begin
                st_nxt.settings = `MSC_SETTINGS_DEFAULT;
                st_nxt.att      = 1'b0;
                st_nxt.dnr      = 1'b1;
                if (reset_level_n) begin
                    st_nxt.state = msc_pkg::MSC_ST_INIT;
                end
            end
            msc_pkg::MSC_ST_INIT: begin
                if (init_done) begin
                    st_nxt.state = msc_pkg::MSC_ST_READY;
                    st_nxt.dnr   = 1'b0;
                    st_nxt.att   = 1'b1;
                end
            end
            msc_pkg::MSC_ST_READY: begin
                if (fault_event || critical_event) begin
                    st_nxt.att = 1'b1;
                end else if (status_read && !select_n_input) begin
                    st_nxt.att = 1'b0;
                end
            end
            default: begin
                st_nxt.state = msc_pkg::MSC_ST_IDLE;
            end
        endcase
        if (long_low) begin
            st_nxt.state    = msc_pkg::MSC_ST_HELD;
            st_nxt.settings = `MSC_SETTINGS_DEFAULT;
            st_nxt.dnr      = 1'b1;
            st_nxt.att      = 1'b0;
        end
        st_nxt.lp    = power_save_input;
        st_nxt.ack   = serial_req && !select_n_input;
        st_nxt.tx_en = ~tx_dis_eff & {NUM_ENDS{~power_save_input}};
        st_nxt.los   = loss_detect;
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r          <= '0;
            st_r.dnr      <= 1'b1;
            st_r.settings <= `MSC_SETTINGS_DEFAULT;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    logic present_r;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            present_r <= 1'b0;
        end else begin
            present_r <= 1'b0;
        end
    end

    assign attention_n_out     = 1'b0;
    assign attention_n_oe      = st_r.att;
    assign present_n_output    = present_r;
    assign data_not_ready      = st_r.dnr;
    assign low_power_active    = st_r.lp;
    assign serial_ack          = st_r.ack;
    assign user_settings       = st_r.settings;
    assign tx_enable           = st_r.tx_en;
    assign tx_fault            = '0;
    assign absent_indication   = '0;
    assign receive_signal_lost = st_r.los;

    // Rate selects have no function
    logic unused_rs;
    assign unused_rs = ^{rate_select_zero, rate_select_one};
endmodule // msc_sideband
`default_nettype wire

// [bench/msc_sideband_properties.sv]
// Port-level checks of the sideband control block
`include "msc_defines.svh"
`default_nettype none
module msc_sideband_properties #(
    parameter int NUM_ENDS  = `MSC_NUM_ENDS,
    parameter int PULSE_CYC = `MSC_RESET_PULSE_CYC,
    parameter int INIT_CYC  = `MSC_INIT_TIME_CYC
) (
    // Clock and reset
    input wire logic                       ref_clk,
    input wire logic                       rst_n,
    // Host side inputs
    input wire logic                       reset_n_input,
    input wire logic                       reset_n_driven,
    input wire logic                       power_save_input,
    input wire logic                       select_n_input,
    input wire logic                       serial_req,
    input wire logic                       fault_event,
    input wire logic                       critical_event,
    input wire logic [NUM_ENDS-1:0]        tx_disable_in,
    input wire logic [NUM_ENDS-1:0]        tx_disable_driven,
    // Device outputs
    input wire logic                       attention_n_out,
    input wire logic                       attention_n_oe,
    input wire logic                       present_n_output,
    input wire logic                       data_not_ready,
    input wire logic                       low_power_active,
    input wire logic                       serial_ack,
    input wire logic [`MSC_SETTINGS_W-1:0] user_settings,
    input wire logic [NUM_ENDS-1:0]        tx_enable,
    input wire logic [NUM_ENDS-1:0]        tx_fault,
    input wire logic [NUM_ENDS-1:0]        absent_indication
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****************
    // Checks
    // ****************
    logic                held_low;
    logic                ack_want;
    logic [NUM_ENDS-1:0] tx_want;
    assign held_low = reset_n_driven && !reset_n_input;
    assign ack_want = serial_req && !select_n_input;
    assign tx_want  = tx_disable_driven & ~tx_disable_in & {NUM_ENDS{~power_save_input}};
    // Consecutive low samples of the reset pin, and cycles of an initialization span
    int low_cnt;
    int span_cnt;
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            low_cnt  <= 0;
            span_cnt <= 0;
        end else begin
            low_cnt  <= !held_low ? 0 : (low_cnt > PULSE_CYC ? low_cnt : low_cnt + 1);
            span_cnt <= (held_low || !data_not_ready) ? 0 : span_cnt + 1;
        end
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    chk_present_low: assert property (present_n_output == 1'b0)
        else $error("presence output not low");
    chk_fault_ground: assert property (tx_fault == '0)
        else $error("transmit fault output not low");
    chk_absent_ground: assert property (absent_indication == '0)
        else $error("absent indication not low");
    chk_pin_pulls_low: assert property (attention_n_out == 1'b0)
        else $error("attention pin driven high");
    chk_tx_gate: assert property ($past(rst_n) |-> tx_enable == $past(tx_want))
        else $error("transmit enable wrong");
    chk_low_power: assert property ($past(rst_n) |-> low_power_active == $past(power_save_input))
        else $error("low power state wrong");
    chk_select_gate: assert property ($past(rst_n) |-> serial_ack == $past(ack_want))
        else $error("serial answer ignores select");
    chk_done_attn: assert property ($fell(data_not_ready) |-> attention_n_oe)
        else $error("completion without attention");
    chk_event_attn: assert property ((fault_event || critical_event) && !data_not_ready
        && !$past(held_low) |=> attention_n_oe)
        else $error("event without attention");
    chk_long_reset: assert property (low_cnt > PULSE_CYC |-> data_not_ready && !attention_n_oe
        && user_settings == `MSC_SETTINGS_DEFAULT)
        else $error("long reset pulse not honoured");
    chk_init_span: assert property ($fell(data_not_ready) |-> span_cnt >= INIT_CYC + 2
        && span_cnt <= INIT_CYC + 3)
        else $error("initialization span wrong");
    cover property ($fell(data_not_ready));
    cover property (serial_ack);
    cover property (low_cnt > PULSE_CYC);
endmodule // msc_sideband_properties
bind msc_sideband msc_sideband_properties #(
    .NUM_ENDS  (NUM_ENDS),
    .PULSE_CYC (PULSE_CYC),
    .INIT_CYC  (INIT_CYC)
) u_props (
    .ref_clk           (ref_clk),
    .rst_n             (rst_n),
    .reset_n_input     (reset_n_input),
    .reset_n_driven    (reset_n_driven),
    .power_save_input  (power_save_input),
    .select_n_input    (select_n_input),
    .serial_req        (serial_req),
    .fault_event       (fault_event),
    .critical_event    (critical_event),
    .tx_disable_in     (tx_disable_in),
    .tx_disable_driven (tx_disable_driven),
    .attention_n_out   (attention_n_out),
    .attention_n_oe    (attention_n_oe),
    .present_n_output  (present_n_output),
    .data_not_ready    (data_not_ready),
    .low_power_active  (low_power_active),
    .serial_ack        (serial_ack),
    .user_settings     (user_settings),
    .tx_enable         (tx_enable),
    .tx_fault          (tx_fault),
    .absent_indication (absent_indication)
);
`default_nettype wire

// [bench/msc_host_model.sv]
// Host board model: attention pull-up and status servicing
`default_nettype none
module msc_host_model (
    // Clock and reset
    input wire logic  ref_clk,
    input wire logic  rst_n,
    // Attention pin drive from the device
    input wire logic  attention_n_out,
    input wire logic  attention_n_oe,
    // Servicing allowed; low stops the host from reading status at all
    input wire logic  service_en,
    // Pin level and status read
    output logic      attention_pin,
    output var logic  status_read
);
    timeunit 1ns;
    timeprecision 1ps;
    assign attention_pin = attention_n_oe ? attention_n_out : 1'b1;
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            status_read <= 1'b0;
        end else begin
            status_read <= service_en && !attention_pin && !status_read;
        end
    end
endmodule // msc_host_model
`default_nettype wire

// [bench/msc_sideband_tb.sv]
// Self-checking testbench of the sideband control block
`default_nettype none
module msc_sideband_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int N = 4;
    localparam int INIT = 10;
    typedef struct packed {
        logic ps; logic sel_n; logic req;
        logic [3:0] dis; logic [3:0] drv; logic [3:0] los; logic [3:0] txe; logic ack;
    } msc_row_t;
    logic ref_clk = 0, rst_n = 0, rst_in = 1, rst_drv = 1, ps = 0, sel_n = 1, req = 0;
    logic fault = 0, crit = 0, svc = 0, pin, rd, a_out, a_oe, prs, dnr, lpa, ack;
    logic [7:0] us;
    logic [N-1:0] dis = 0, drv = 4'hF, rs0 = 0, rs1 = 0, los = 0, txe, txf, abs_o, rsl;
    int miscompares = 0, total_checks = 0, n;
    msc_row_t rows [4] = '{{1'h0, 1'h0, 1'h1, 4'h0, 4'hF, 4'hA, 4'hF, 1'h1},
        {1'h0, 1'h1, 1'h1, 4'h5, 4'hF, 4'h5, 4'hA, 1'h0},
        {1'h0, 1'h0, 1'h0, 4'h0, 4'h3, 4'h0, 4'h3, 1'h0},
        {1'h1, 1'h0, 1'h1, 4'h0, 4'hF, 4'hF, 4'h0, 1'h1}};
    msc_sideband #(.PULSE_CYC(3), .INIT_CYC(INIT)) dut (.ref_clk, .rst_n,
        .reset_n_input(rst_in), .reset_n_driven(rst_drv), .power_save_input(ps),
        .select_n_input(sel_n), .serial_req(req), .status_read(rd), .fault_event(fault),
        .critical_event(crit), .tx_disable_in(dis), .tx_disable_driven(drv),
        .rate_select_zero(rs0), .rate_select_one(rs1), .loss_detect(los),
        .attention_n_out(a_out), .attention_n_oe(a_oe), .present_n_output(prs),
        .data_not_ready(dnr), .low_power_active(lpa), .serial_ack(ack), .user_settings(us),
        .tx_enable(txe), .tx_fault(txf), .absent_indication(abs_o), .receive_signal_lost(rsl));
    msc_host_model host (.ref_clk, .rst_n, .attention_n_out(a_out), .attention_n_oe(a_oe),
        .service_en(svc), .attention_pin(pin), .status_read(rd));
    always #20 ref_clk = ~ref_clk;
    task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d miscompares %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge ref_clk);
        #1;
    endtask
    // Pin released (which=1) or init over (which=0), bounded
    task automatic wait_for(input logic which, output int cnt);
        cnt = 0;
        while ((which ? pin !== 1'b1 : dnr !== 1'b0) && cnt < 60) begin
            tick(1);
            cnt++;
        end
        if (cnt >= 60) begin
            miscompares++;
            end_sim();
        end
    endtask
    // ****************
    // Main sequence
    // ****************
    initial begin
        tick(11);
        cmp("dnr_in_reset", 8'h01, 8'(dnr));
        @(posedge ref_clk);
        rst_n <= 1'b1;
        wait_for(1'b0, n);
        cmp("powerup_span", 8'h01, 8'(n >= INIT));
        cmp("powerup_attn", 8'h00, 8'(pin));
        cmp("present", 8'h00, 8'(prs));
        cmp("grounded", 8'h00, {txf, abs_o});
        cmp("settings", 8'h00, us);
        foreach (rows[i]) begin
            @(posedge ref_clk);
            ps <= rows[i].ps;
            sel_n <= rows[i].sel_n;
            req <= rows[i].req;
            dis <= rows[i].dis;
            drv <= rows[i].drv;
            los <= rows[i].los;
            rs0 <= 4'(i);
            rs1 <= ~4'(i);
            tick(1);
            cmp("tx_enable", 8'(rows[i].txe), 8'(txe));
            cmp("serial_ack", 8'(rows[i].ack), 8'(ack));
            cmp("low_power", 8'(rows[i].ps), 8'(lpa));
            cmp("loss", 8'(rows[i].los), 8'(rsl));
        end
        @(posedge ref_clk);
        sel_n <= 1'b0;
        svc <= 1'b1;
        wait_for(1'b1, n);
        cmp("attn_cleared", 8'h01, 8'(pin));
        for (int k = 0; k < 2; k++) begin
            @(posedge ref_clk);
            svc <= 1'b0;
            fault <= (k == 0);
            crit <= (k == 1);
            @(posedge ref_clk);
            fault <= 1'b0;
            crit <= 1'b0;
            tick(1);
            cmp("event_attn", 8'h00, 8'(pin));
            @(posedge ref_clk);
            svc <= 1'b1;
            wait_for(1'b1, n);
        end
        @(posedge ref_clk);
        svc <= 1'b0;
        rst_in <= 1'b0;
        repeat (2) @(posedge ref_clk);
        rst_in <= 1'b1;
        tick(4);
        cmp("short_pulse", 8'h00, 8'(dnr));
        @(posedge ref_clk);
        rst_in <= 1'b0;
        fault <= 1'b1;
        @(posedge ref_clk);
        fault <= 1'b0;
        tick(5);
        cmp("held_dnr", 8'h01, 8'(dnr));
        cmp("held_oe", 8'h00, 8'(a_oe));
        @(posedge ref_clk);
        rst_in <= 1'b1;
        wait_for(1'b0, n);
        cmp("init_span", 8'h01, 8'(n >= INIT));
        cmp("done_attn", 8'h00, 8'(pin));
        @(posedge ref_clk);
        rst_drv <= 1'b0;
        rst_in <= 1'b0;
        tick(8);
        cmp("undriven", 8'h00, 8'(dnr));
        end_sim();
    end
endmodule // msc_sideband_tb
`default_nettype wire
